// ---- logic/rrot_pkg.sv ----
// constants, types and encodings shared by the return and rotate execution unit
package rrot_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int FILE_AW = 7;
  localparam int PC_W    = 15;
  localparam int SP_W    = 5;

  // instruction field positions
  localparam int OPC_LSB = 8;
  localparam int OPC_MSB = 13;
  localparam int DST_BIT = 7;
  localparam int LIT_MSB = 7;

  // opcode encodings, upper six bits unless a full word
  localparam logic [5:0]  OPC_RET_LIT   = 6'h34;
  localparam logic [5:0]  OPC_ROT_LEFT  = 6'h0d;
  localparam logic [5:0]  OPC_ROT_RIGHT = 6'h0c;
  localparam logic [13:0] OPC_RETURN = 14'h0008;

  // reset values
  localparam logic [7:0]  W_RST  = 8'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [4:0]  SP_RST = 5'h00;

  typedef enum logic [2:0] {
    OP_OTHER,
    OP_RET_LIT,
    OP_RETURN,
    OP_ROT_LEFT,
    OP_ROT_RIGHT
  } rrot_op_e;

  typedef enum logic {
    ST_EXEC,
    ST_FLUSH
  } rrot_state_e;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } rrot_status_s;

  typedef struct packed {
    logic                en;
    logic [FILE_AW-1:0]  addr;
    logic [DATA_W-1:0]   data;
  } rrot_file_wr_s;

  localparam rrot_status_s  STATUS_RST  = 3'h0;
  localparam rrot_file_wr_s FILE_WR_RST = 16'h0000;

endpackage : rrot_pkg

// ---- logic/rrot_exec.sv ----
// execution unit for return-with-literal, subroutine return and rotate through carry
// What this block does
// - return_with_literal loads its 8-bit immediate into the working register.
// - return_with_literal loads the program counter from top_of_stack_entry.
// - return_with_literal is one word, two cycles, and leaves status flags alone.
// - rotate_left_through_carry: carry enters low bit, old high bit goes to carry.
// - rotate with destination bit 0 writes working register, source left untouched.
// - rotate_left_through_carry with destination bit 1 writes the source register.
// - rotate_right_through_carry: carry enters high bit, old low bit goes to carry.
// - rotate_right_through_carry with destination bit 1 writes the source register.
// - plain return pops the stack into the program counter in two cycles.
`timescale 1ns/100ps
module rrot_exec
  import rrot_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  input  wire logic                instr_valid_in,
  input  wire logic [INSTR_W-1:0]  instr_in,
  input  wire logic [DATA_W-1:0]   file_rdata_in,
  input  wire logic [PC_W-1:0]     top_of_stack_entry_in,
  input  wire logic                stack_push_in,
  output logic                     instr_ready_out,
  output logic [DATA_W-1:0]        w_out,
  output rrot_status_s             status_out,
  output logic [PC_W-1:0]          pc_out,
  output rrot_file_wr_s            file_wr_out,
  output logic                     stack_pop_out,
  output logic [SP_W-1:0]          stack_depth_out
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic rrot_op_e decode_op(input logic [INSTR_W-1:0] word);
    rrot_op_e op;
    op = OP_OTHER;
    if (word == OPC_RETURN) begin
      op = OP_RETURN;
    end else if (word[OPC_MSB:OPC_LSB] == OPC_RET_LIT) begin
      op = OP_RET_LIT;
    end else if (word[OPC_MSB:OPC_LSB] == OPC_ROT_LEFT) begin
      op = OP_ROT_LEFT;
    end else if (word[OPC_MSB:OPC_LSB] == OPC_ROT_RIGHT) begin
      op = OP_ROT_RIGHT;
    end
    return op;
  endfunction : decode_op

  rrot_state_e         state_q, state_d;
  logic                ready_q, ready_d;
  logic [DATA_W-1:0]   w_q, w_d;
  rrot_status_s        status_q, status_d;
  logic [PC_W-1:0]     pc_q, pc_d;
  rrot_file_wr_s       file_wr_q, file_wr_d;
  logic                pop_q, pop_d;
  logic [SP_W-1:0]     sp_q, sp_d;
  logic                accept;
  rrot_op_e            op;
  logic [DATA_W-1:0]   rot_res;
  logic                rot_carry;
  logic                pop_now;

  assign accept = instr_valid_in & ready_q;
  assign op     = decode_op(instr_in);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d   = state_q;
    w_d       = w_q;
    status_d  = status_q;
    pc_d      = pc_q;
    file_wr_d = FILE_WR_RST;
    pop_now   = 1'b0;
    rot_res   = file_rdata_in;
    rot_carry = status_q.c;
    if (op == OP_ROT_RIGHT) begin
      rot_res   = {status_q.c, file_rdata_in[DATA_W-1:1]};
      rot_carry = file_rdata_in[0];
    end else begin
      rot_res   = {file_rdata_in[DATA_W-2:0], status_q.c};
      rot_carry = file_rdata_in[DATA_W-1];
    end
    case (state_q)
      ST_EXEC: begin
        if (accept) begin
          pc_d = pc_q + 15'h0001;
          case (op)
            OP_RET_LIT: begin
              w_d     = instr_in[LIT_MSB:0];
              pc_d    = top_of_stack_entry_in;
              pop_now = 1'b1;
              state_d = ST_FLUSH;
            end
            OP_RETURN: begin
              pc_d    = top_of_stack_entry_in;
              pop_now = 1'b1;
              state_d = ST_FLUSH;
            end
            OP_ROT_LEFT, OP_ROT_RIGHT: begin
              status_d.c = rot_carry;
              if (instr_in[DST_BIT]) begin
                file_wr_d.en   = 1'b1;
                file_wr_d.addr = instr_in[FILE_AW-1:0];
                file_wr_d.data = rot_res;
              end else begin
                w_d = rot_res;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_FLUSH: begin
        // second cycle of a return: fetched word is discarded
        state_d = ST_EXEC;
      end
      default: begin
        state_d = ST_EXEC;
      end
    endcase
    ready_d = (state_d == ST_EXEC);
    pop_d   = pop_now;
    // push from a call and pop may meet; net depth change is zero
    sp_d    = sp_q + {4'h0, stack_push_in} - {4'h0, pop_now};
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_q   <= ST_EXEC;
      ready_q   <= 1'b0;
      w_q       <= W_RST;
      status_q  <= STATUS_RST;
      pc_q      <= PC_RST;
      file_wr_q <= FILE_WR_RST;
      pop_q     <= 1'b0;
      sp_q      <= SP_RST;
    end else begin
      state_q   <= state_d;
      ready_q   <= ready_d;
      w_q       <= w_d;
      status_q  <= status_d;
      pc_q      <= pc_d;
      file_wr_q <= file_wr_d;
      pop_q     <= pop_d;
      sp_q      <= sp_d;
    end
  end

  assign instr_ready_out = ready_q;
  assign w_out           = w_q;
  assign status_out      = status_q;
  assign pc_out          = pc_q;
  assign file_wr_out     = file_wr_q;
  assign stack_pop_out   = pop_q;
  assign stack_depth_out = sp_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence ret_lit_go;
    accept && (op == OP_RET_LIT);
  endsequence

  sequence two_cycle_flush;
    !ready_q ##1 ready_q;
  endsequence

  sequence rot_go(logic [5:0] code, logic dst);
    accept && (instr_in[OPC_MSB:OPC_LSB] == code) && (instr_in[DST_BIT] == dst);
  endsequence

  lit_load_a: assert property (
    ret_lit_go |=> (w_q == $past(instr_in[LIT_MSB:0])))
    else $error("literal not loaded into working register");

  lit_ret_pc_a: assert property (
    ret_lit_go |=> (pc_q == $past(top_of_stack_entry_in)) && stack_pop_out)
    else $error("return address not taken from stack top");

  lit_ret_timing_a: assert property (
    ret_lit_go |=> two_cycle_flush and ($stable(status_q) [*2]))
    else $error("literal return not two cycles or flags changed");

  left_rotate_a: assert property (
    rot_go(OPC_ROT_LEFT, 1'b0) |=> (status_q.c == $past(file_rdata_in[7]))
      && (w_q == {$past(file_rdata_in[6:0]), $past(status_q.c)}))
    else $error("left rotate result or carry wrong");

  dest_w_a: assert property (
    accept && (op == OP_ROT_LEFT || op == OP_ROT_RIGHT) && !instr_in[DST_BIT]
      |=> !file_wr_out.en)
    else $error("source register written with destination bit clear");

  left_writeback_a: assert property (
    rot_go(OPC_ROT_LEFT, 1'b1) |=> file_wr_out.en && $stable(w_q)
      && (file_wr_out.addr == $past(instr_in[6:0]))
      && (file_wr_out.data == {$past(file_rdata_in[6:0]), $past(status_q.c)}))
    else $error("left rotate write-back wrong");

  right_rotate_a: assert property (
    rot_go(OPC_ROT_RIGHT, 1'b0) |=> (status_q.c == $past(file_rdata_in[0]))
      && (w_q == {$past(status_q.c), $past(file_rdata_in[7:1])}))
    else $error("right rotate result or carry wrong");

  right_writeback_a: assert property (
    rot_go(OPC_ROT_RIGHT, 1'b1) |=> file_wr_out.en && $stable(w_q)
      && (file_wr_out.data == {$past(status_q.c), $past(file_rdata_in[7:1])}))
    else $error("right rotate write-back wrong");

  return_pop_a: assert property (
    accept && (op == OP_RETURN) |=> stack_pop_out
      && (pc_q == $past(top_of_stack_entry_in)) ##0 two_cycle_flush)
    else $error("subroutine return did not pop in two cycles");

  rotate_single_a: assert property (
    accept && (op == OP_ROT_LEFT || op == OP_ROT_RIGHT) |=> ready_q
      && (status_q.z == $past(status_q.z)) && (status_q.dc == $past(status_q.dc))
      && (pc_q == $past(pc_q) + 15'h0001))
    else $error("rotate not single cycle or touched other flags");

  lit_depth_a: assert property (
    (ret_lit_go and !stack_push_in) |=> (sp_q == $past(sp_q) - 5'h01))
    else $error("literal return did not reduce stack depth");

endmodule : rrot_exec

// ---- test/rrot_exec_tb.sv ----
// self-checking bench for the return and rotate execution unit
`timescale 1ns/100ps
module rrot_exec_tb
  import rrot_pkg::*;
;
  logic                clk_sys_in = 1'b0;
  logic                rst_n_in = 1'b0;
  logic                instr_valid_in = 1'b0;
  logic [INSTR_W-1:0]  instr_in = 14'h0000;
  logic [DATA_W-1:0]   file_rdata_in = 8'h00;
  logic [PC_W-1:0]     top_of_stack_entry_in = 15'h0000;
  logic                stack_push_in = 1'b0;
  logic                instr_ready_out;
  logic [DATA_W-1:0]   w_out;
  rrot_status_s        status_out;
  logic [PC_W-1:0]     pc_out;
  rrot_file_wr_s       file_wr_out;
  logic                stack_pop_out;
  logic [SP_W-1:0]     stack_depth_out;
  logic [DATA_W-1:0]   exp_w = 8'h00;
  logic                exp_c = 1'b0;
  logic [PC_W-1:0]     exp_pc = 15'h0000;
  logic [SP_W-1:0]     exp_depth = 5'h00;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  rrot_exec i_rrot_exec (
    .clk_sys_in            (clk_sys_in),
    .rst_n_in              (rst_n_in),
    .instr_valid_in        (instr_valid_in),
    .instr_in              (instr_in),
    .file_rdata_in         (file_rdata_in),
    .top_of_stack_entry_in (top_of_stack_entry_in),
    .stack_push_in         (stack_push_in),
    .instr_ready_out       (instr_ready_out),
    .w_out                 (w_out),
    .status_out            (status_out),
    .pc_out                (pc_out),
    .file_wr_out           (file_wr_out),
    .stack_pop_out         (stack_pop_out),
    .stack_depth_out       (stack_depth_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // working register, program counter, status flags and stack depth are compared after every operation
  task automatic check_state();
    check_val(16'(w_out), 16'(exp_w));
    check_val(16'(pc_out), 16'(exp_pc));
    check_val(16'(status_out), {13'h0000, 2'b00, exp_c});
    check_val(16'(stack_depth_out), 16'(exp_depth));
  endtask : check_state

  // bounded wait, sampled where outputs have settled
  task automatic wait_ready();
    int n;
    n = 0;
    while (instr_ready_out !== 1'b1) begin
      @(posedge clk_sys_in);
      #1;
      n++;
      if (n > 20) begin
        n_mismatch++;
        give_verdict();
      end
    end
  endtask : wait_ready

  task automatic send(input logic [13:0] word, input logic [7:0] rdata, input logic [14:0] ret);
    wait_ready();
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b1;
    instr_in <= word;
    file_rdata_in <= rdata;
    top_of_stack_entry_in <= ret;
    @(posedge clk_sys_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask : send

  ////////////////////////////////////////////////////////////////////////////////
  task automatic push_frames(input int n);
    @(posedge clk_sys_in);
    stack_push_in <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    stack_push_in <= 1'b0;
    #1;
    exp_depth = exp_depth + 5'(n);
    check_state();
  endtask : push_frames

  // literal return when with_lit, else plain return; both flush one cycle
  task automatic run_return(input logic with_lit, input logic [7:0] k, input logic [14:0] ret);
    send(with_lit ? {OPC_RET_LIT, k} : OPC_RETURN, 8'h00, ret);
    if (with_lit) exp_w = k;
    exp_pc = ret;
    exp_depth = exp_depth - 5'h01;
    check_state();
    check_val(16'(stack_pop_out), 16'h0001);
    check_val(16'(instr_ready_out), 16'h0000);
    @(posedge clk_sys_in);
    #1;
    check_val({15'h0000, stack_pop_out}, 16'h0000);
    check_val({15'h0000, instr_ready_out}, 16'h0001);
  endtask : run_return

  task automatic run_rotate(input logic left, input logic d, input logic [6:0] f,
                            input logic [7:0] r);
    logic [7:0] res;
    res = left ? {r[6:0], exp_c} : {exp_c, r[7:1]};
    send({(left ? OPC_ROT_LEFT : OPC_ROT_RIGHT), d, f}, r, 15'h7fff);
    exp_c = left ? r[7] : r[0];
    exp_pc = exp_pc + 15'h0001;
    if (!d) exp_w = res;
    check_state();
    check_val(16'(file_wr_out), d ? {1'b1, f, res} : 16'h0000);
    @(posedge clk_sys_in);
    #1;
    check_val({15'h0000, file_wr_out.en}, 16'h0000);
  endtask : run_rotate

  // an unrelated word only steps the program counter
  task automatic run_other();
    send(14'h0000, 8'hff, 15'h0000);
    exp_pc = exp_pc + 15'h0001;
    check_state();
    check_val({15'h0000, stack_pop_out}, 16'h0000);
    check_val(16'(file_wr_out), 16'h0000);
    check_val({15'h0000, instr_ready_out}, 16'h0001);
  endtask : run_other

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    check_state();
    push_frames(4);
    run_rotate(1'b1, 1'b0, 7'h20, 8'he6);
    run_rotate(1'b1, 1'b1, 7'h7f, 8'h81);
    run_rotate(1'b0, 1'b0, 7'h00, 8'h01);
    run_rotate(1'b0, 1'b1, 7'h45, 8'h80);
    run_return(1'b1, 8'h00, 15'h1234);
    run_return(1'b1, 8'hff, 15'h7ffe);
    run_rotate(1'b1, 1'b1, 7'h11, 8'h7e);
    run_return(1'b0, 8'h00, 15'h0abc);
    run_return(1'b1, 8'h5a, 15'h0001);
    run_other();
    give_verdict();
  end

endmodule : rrot_exec_tb
